// ### src/qdc_pin_sync.sv
// Purpose: Two-flop synchroniser for the serial link pins.
// Assumes: Inputs are asynchronous to clock.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/1ps
module qdc_pin_sync #(
  parameter int         WIDTH     = 6,
  parameter logic [5:0] RESET_VAL = 6'h00
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_reg;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (rst) begin
        stage1_reg[i] <= RESET_VAL[i];
        pinOut[i]     <= RESET_VAL[i];
      end else begin
        stage1_reg[i] <= pinIn[i];
        pinOut[i]     <= stage1_reg[i];
      end
    end
  end
endmodule

// ### src/qdc_pkg.sv
// Purpose: Types shared by the quad converter control modules.
// Assumes: qdc_regs.svh holds the codes, offsets and reset values.
// Notes:   Struct fields are listed most significant first.
package qdc_pkg;
  `include "qdc_regs.svh"

  typedef logic [15:0] qdc_code_type;

  typedef struct packed {
    logic serialClock;
    logic frameSelectN;
    logic serialDataIn;
    logic loadOutputsN;
    logic clearOutputsN;
    logic codingSelect;
  } qdc_link_pins_type;

  typedef struct packed {
    logic         readWrite;
    logic         reserved;
    logic [2:0]   targetSelect;
    logic [2:0]   channelSelect;
    qdc_code_type data;
  } qdc_frame_type;

  typedef struct packed {
    logic groundAdjust;
    logic io1Direction;
    logic io1Value;
    logic io0Direction;
    logic io0Value;
    logic outputPinDisable;
  } qdc_func_type;
endpackage

// ### src/qdc_regs.svh
// Purpose: Offsets, field positions, codes and reset values of the quad converter control.
// Assumes: Included by its bare name from the package only.
// Notes:   Definitions only.
`ifndef QDC_REGS_SVH
`define QDC_REGS_SVH

// Serial frame
`define QDC_FRAME_BITS      5'h18
`define QDC_COUNT_SATURATE  5'h19
`define QDC_DATA_BITS       16
`define QDC_FUNC_BITS       6

// Target select codes
`define QDC_TSEL_FUNCTION   3'h0
`define QDC_TSEL_DATA       3'h2
`define QDC_TSEL_COARSE     3'h3
`define QDC_TSEL_FINE       3'h4
`define QDC_TSEL_OFFSET     3'h5

// Channel select codes, and function codes under target 000
`define QDC_CSEL_ALL        3'h4
`define QDC_FN_NO_OPERATION 3'h0
`define QDC_FN_CONTROL      3'h1
`define QDC_FN_CLEAR        3'h4
`define QDC_FN_LOAD         3'h5

// Codes and reset values
`define QDC_ZERO_CODE       16'h0000
`define QDC_SIGN_FLIP       16'h8000
`define QDC_FINE_MASK       16'h003F
`define QDC_FUNC_RESET      6'h00
`define QDC_PIN_RESET       6'h36
`define QDC_CTRL_RESET      1'h0
`define QDC_ERR_RESET       8'h00

// Bus map: word offsets and register groups (address bits 7:4)
`define QDC_CTRL_OFFSET     8'h00
`define QDC_STATUS_OFFSET   8'h04
`define QDC_GRP_MISC        4'h0
`define QDC_GRP_OUTPUT      4'h1
`define QDC_GRP_INPUT       4'h2
`define QDC_GRP_COARSE      4'h3
`define QDC_GRP_FINE        4'h4
`define QDC_GRP_OFFSET      4'h5

// Field positions
`define QDC_CTRL_DAISY_BIT  0
`define QDC_ST_CLAMP_BIT    0
`define QDC_ST_CODING_BIT   1
`define QDC_ST_PEND_BIT     2
`define QDC_ST_ERR_LSB      8
`define QDC_ST_FUNC_LSB     16

`endif

// ### src/qdc_serial_load_control.sv
// Purpose: Serial load, readback, update and clear control of a quad 16-bit converter.
// Assumes: Link pins are sampled by clock; Wishbone classic slave for status.
// Notes:   dacCode carries the ladder code; outputsClamped means the outputs are held at 0 V.
`timescale 1ns/1ps
module qdc_serial_load_control
  import qdc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire qdc_link_pins_type linkPins,
  output logic                   serialDataOut,
  output qdc_code_type [3:0]     dacCode,
  output logic                   outputsClamped,
  output qdc_func_type           funcControl,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic                   wb_ack_o,
  output logic [31:0]            wb_dat_o
);

  qdc_link_pins_type pinNow;
  qdc_link_pins_type pinPrev_reg;
  logic [23:0]       shift_reg;
  logic [4:0]        bitCount_reg;
  logic              readPending_reg;
  logic [5:0]        readSel_reg;
  logic              daisyMode_reg;
  logic [7:0]        invalidCount_reg;
  logic              clamped_reg;
  qdc_func_type      func_reg;
  qdc_code_type      inData_reg  [4];
  qdc_code_type      outData_reg [4];
  qdc_code_type      coarse_reg  [4];
  qdc_code_type      fine_reg    [4];
  qdc_code_type      offset_reg  [4];

  logic          sclkFall;
  logic          sclkRise;
  logic          frameStart;
  logic          frameEnd;
  logic          loadFall;
  logic          clearFall;
  logic          frameValid;
  logic          writeOk;
  logic          functionWrite;
  logic          dataWrite;
  logic          loadHeldLow;
  logic          clearEvent;
  logic          loadEvent;
  logic [3:0]    chanHit;
  qdc_frame_type frame;
  qdc_code_type  readData;
  qdc_code_type  flipMask;
  logic          wbReq;
  logic [31:0]   wbReadMux;
  logic [1:0]    wbChan;
  logic          ctrlWrite;
  logic [31:0]   statusWord;

  qdc_pin_sync #(
    .WIDTH     (6),
    .RESET_VAL (`QDC_PIN_RESET)
  ) u_pin_sync (
    .clock  (clock),
    .rst    (rst),
    .pinIn  (linkPins),
    .pinOut (pinNow)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge clock) begin
    if (rst) begin
      pinPrev_reg <= qdc_link_pins_type'(`QDC_PIN_RESET);
    end else begin
      pinPrev_reg <= pinNow;
    end
  end

  assign sclkFall   = pinPrev_reg.serialClock & ~pinNow.serialClock;
  assign sclkRise   = ~pinPrev_reg.serialClock & pinNow.serialClock;
  assign frameStart = pinPrev_reg.frameSelectN & ~pinNow.frameSelectN;
  assign frameEnd   = ~pinPrev_reg.frameSelectN & pinNow.frameSelectN;
  assign loadFall   = pinPrev_reg.loadOutputsN & ~pinNow.loadOutputsN;
  // The clear pin resets high, so a clear held low at power-on shows as a fall
  assign clearFall  = pinPrev_reg.clearOutputsN & ~pinNow.clearOutputsN;

  // Shift register and edge count
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_reg    <= 24'h00_0000;
      bitCount_reg <= 5'h00;
    end else if (frameStart) begin
      bitCount_reg <= 5'h00;
      if (readPending_reg) begin
        shift_reg <= {8'h00, readData};
      end
    end else if (~pinNow.frameSelectN && sclkFall) begin
      shift_reg <= {shift_reg[22:0], pinNow.serialDataIn};
      if (bitCount_reg != `QDC_COUNT_SATURATE) begin
        bitCount_reg <= bitCount_reg + 5'h01;
      end
    end
  end

  // Standalone needs exactly 24 edges; daisy mode keeps the last 24 of more
  assign frameValid = frameEnd && ((bitCount_reg == `QDC_FRAME_BITS) ||
                      (daisyMode_reg && bitCount_reg == `QDC_COUNT_SATURATE));
  assign frame         = qdc_frame_type'(shift_reg);
  assign writeOk       = frameValid & ~frame.readWrite;
  assign functionWrite = writeOk && frame.targetSelect == `QDC_TSEL_FUNCTION;
  assign dataWrite     = writeOk && frame.targetSelect == `QDC_TSEL_DATA;
  assign loadHeldLow   = ~pinNow.loadOutputsN;
  assign clearEvent    = clearFall ||
                         (functionWrite && frame.channelSelect == `QDC_FN_CLEAR);
  assign loadEvent     = loadFall ||
                         (functionWrite && frame.channelSelect == `QDC_FN_LOAD);

  // Readback select
  always_ff @(posedge clock) begin
    if (rst) begin
      readPending_reg <= 1'b0;
      readSel_reg     <= 6'h00;
    end else if (frameValid) begin
      readPending_reg <= frame.readWrite;
      readSel_reg     <= {frame.targetSelect, frame.channelSelect};
    end
  end

  always_comb begin
    readData = `QDC_ZERO_CODE;
    unique case (readSel_reg[5:3])
      `QDC_TSEL_DATA:    readData = inData_reg[readSel_reg[1:0]];
      `QDC_TSEL_COARSE:  readData = coarse_reg[readSel_reg[1:0]];
      `QDC_TSEL_FINE:    readData = fine_reg[readSel_reg[1:0]];
      `QDC_TSEL_OFFSET:  readData = offset_reg[readSel_reg[1:0]];
      `QDC_TSEL_FUNCTION: begin
        if (readSel_reg[2:0] == `QDC_FN_CONTROL) begin
          readData = {10'h000, func_reg};
        end
      end
      default:           readData = `QDC_ZERO_CODE;
    endcase
  end

  // Serial output: launched on rising clock, idle low when disabled
  always_ff @(posedge clock) begin
    if (rst) begin
      serialDataOut <= 1'b0;
    end else if (func_reg.outputPinDisable) begin
      serialDataOut <= 1'b0;
    end else if (frameStart) begin
      serialDataOut <= readPending_reg ? 1'b0 : shift_reg[23];
    end else if (~pinNow.frameSelectN && sclkRise) begin
      serialDataOut <= shift_reg[23];
    end
  end

  // Function control bits
  always_ff @(posedge clock) begin
    if (rst) begin
      func_reg <= qdc_func_type'(`QDC_FUNC_RESET);
    end else if (functionWrite && frame.channelSelect == `QDC_FN_CONTROL) begin
      func_reg <= qdc_func_type'(frame.data[5:0]);
    end
  end

  assign funcControl = func_reg;

  // Channel registers
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    assign chanHit[ch] = (frame.channelSelect == 3'(ch)) ||
                         (frame.channelSelect == `QDC_CSEL_ALL);

    // Clear beats load and writes in the same cycle
    always_ff @(posedge clock) begin
      if (rst) begin
        inData_reg[ch]  <= `QDC_ZERO_CODE;
        outData_reg[ch] <= `QDC_ZERO_CODE;
      end else if (clearEvent) begin
        inData_reg[ch]  <= `QDC_ZERO_CODE;
        outData_reg[ch] <= `QDC_ZERO_CODE;
      end else begin
        if (dataWrite && chanHit[ch]) begin
          inData_reg[ch] <= frame.data;
        end
        if (loadEvent) begin
          outData_reg[ch] <= inData_reg[ch];
        end
        // Individual write wins over a same-cycle load
        if (dataWrite && chanHit[ch] && loadHeldLow) begin
          outData_reg[ch] <= frame.data;
        end
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        coarse_reg[ch] <= `QDC_ZERO_CODE;
        fine_reg[ch]   <= `QDC_ZERO_CODE;
        offset_reg[ch] <= `QDC_ZERO_CODE;
      end else if (writeOk && chanHit[ch]) begin
        if (frame.targetSelect == `QDC_TSEL_COARSE) begin
          coarse_reg[ch] <= frame.data;
        end
        if (frame.targetSelect == `QDC_TSEL_FINE) begin
          fine_reg[ch] <= frame.data & `QDC_FINE_MASK;
        end
        if (frame.targetSelect == `QDC_TSEL_OFFSET) begin
          offset_reg[ch] <= frame.data;
        end
      end
    end

    // Ladder code: with coding select low, twos complement is turned to offset binary
    always_ff @(posedge clock) begin
      if (rst) begin
        dacCode[ch] <= `QDC_ZERO_CODE;
      end else begin
        dacCode[ch] <= outData_reg[ch] ^ flipMask;
      end
    end
  end

  assign flipMask = pinNow.codingSelect ? `QDC_ZERO_CODE : `QDC_SIGN_FLIP;

  // Output clamp released by the first update or clear
  always_ff @(posedge clock) begin
    if (rst) begin
      clamped_reg <= 1'b1;
    end else if (clearEvent || loadEvent || (dataWrite && loadHeldLow)) begin
      clamped_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      outputsClamped <= 1'b1;
    end else begin
      outputsClamped <= clamped_reg;
    end
  end

  // Invalid frames only bump a counter
  always_ff @(posedge clock) begin
    if (rst) begin
      invalidCount_reg <= `QDC_ERR_RESET;
    end else if (frameEnd && !frameValid) begin
      invalidCount_reg <= invalidCount_reg + 8'h01;
    end
  end

  // Wishbone classic slave, one registered answer the cycle after each request
  assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbChan = wb_adr_i[3:2];
  // Writes land at the taking edge, the same edge that raises ack
  assign ctrlWrite = wbReq && wb_we_i && (wb_adr_i == `QDC_CTRL_OFFSET) && wb_sel_i[0];

  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      daisyMode_reg <= `QDC_CTRL_RESET;
    end else if (ctrlWrite) begin
      daisyMode_reg <= wb_dat_i[`QDC_CTRL_DAISY_BIT];
    end
  end

  // Status word assembled apart from the address decode
  always_comb begin
    statusWord                        = 32'h0000_0000;
    statusWord[`QDC_ST_CLAMP_BIT]     = clamped_reg;
    statusWord[`QDC_ST_CODING_BIT]    = pinNow.codingSelect;
    statusWord[`QDC_ST_PEND_BIT]      = readPending_reg;
    statusWord[`QDC_ST_ERR_LSB +: 8]  = invalidCount_reg;
    statusWord[`QDC_ST_FUNC_LSB +: 6] = func_reg;
  end

  always_comb begin
    wbReadMux = 32'h0000_0000;
    unique case (wb_adr_i[7:4])
      `QDC_GRP_MISC: begin
        if (wb_adr_i == `QDC_CTRL_OFFSET) begin
          wbReadMux[`QDC_CTRL_DAISY_BIT] = daisyMode_reg;
        end else if (wb_adr_i == `QDC_STATUS_OFFSET) begin
          wbReadMux = statusWord;
        end
      end
      `QDC_GRP_OUTPUT: wbReadMux = {16'h0000, outData_reg[wbChan]};
      `QDC_GRP_INPUT:  wbReadMux = {16'h0000, inData_reg[wbChan]};
      `QDC_GRP_COARSE: wbReadMux = {16'h0000, coarse_reg[wbChan]};
      `QDC_GRP_FINE:   wbReadMux = {16'h0000, fine_reg[wbChan]};
      `QDC_GRP_OFFSET: wbReadMux = {16'h0000, offset_reg[wbChan]};
      default:         wbReadMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      wb_dat_o <= wbReadMux;
    end
  end

endmodule

// ### verif/qdc_host_model.sv
// Purpose: Host serial port model driving frames into the converter.
// Assumes: 64 ns link clock, phase offset from the system clock.
// Notes:   Clock idles high between frames; released data is inverted.
`timescale 1ns/1ps
module qdc_host_model (
  output logic      serialClock,
  output logic      frameSelectN,
  output logic      serialDataIn,
  input  wire logic serialDataOut
);
  initial begin
    serialClock = 1'h1;
    frameSelectN = 1'h1;
    serialDataIn = 1'h0;
  end
  // Sends the low n bits of w MSB first; got collects output bits at each fall
  task automatic frame(input logic [47:0] w, input int n, output logic [47:0] got);
    got = '0;
    #3 frameSelectN = 1'h0;
    #32;
    for (int i = 0; i < n; i++) begin
      serialDataIn = w[n-1-i];
      #32 serialClock = 1'h0;
      got = {got[46:0], serialDataOut};
      #32 serialClock = 1'h1;
    end
    #32 frameSelectN = 1'h1;
    serialDataIn = ~serialDataIn;
    #64;
  endtask
endmodule

// ### verif/qdc_serial_load_control_monitor.sv
// Purpose: Port checker for the quad converter serial load control.
// Assumes: Bound to the design top; one clock domain.
// Notes:   Latency windows allow for the link pin synchronisers.
`timescale 1ns/1ps
module qdc_serial_load_control_monitor
  import qdc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire qdc_link_pins_type linkPins,
  input wire logic              serialDataOut,
  input wire qdc_code_type [3:0] dacCode,
  input wire logic              outputsClamped,
  input wire qdc_func_type      funcControl,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic              wb_ack_o,
  input wire logic [31:0]       wb_dat_o
);
  logic [15:0] clearedCode;
  assign clearedCode = linkPins.codingSelect ? 16'h0000 : 16'h8000;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence clearFall; $fell(linkPins.clearOutputsN); endsequence
  sequence clearHeld; !linkPins.clearOutputsN [*4]; endsequence
  sequence loadFall; $fell(linkPins.loadOutputsN); endsequence
  sequence loadHeld; !linkPins.loadOutputsN [*4]; endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i[7:4] == 4'hF |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_clamp_no_rise: assert property (!outputsClamped |=> !outputsClamped)
    else $error("outputs clamped again");
  a_clear_to_code: assert property (clearFall ##0 clearHeld |-> ##[0:6]
    (dacCode[0] == clearedCode && dacCode[1] == clearedCode
     && dacCode[2] == clearedCode && dacCode[3] == clearedCode))
    else $error("clear pin did not clear outputs");
  a_load_unclamp: assert property (loadFall ##0 loadHeld |-> ##[0:6] !outputsClamped)
    else $error("load fall left outputs clamped");
  a_sdo_disabled: assert property (funcControl.outputPinDisable [*2] |-> !serialDataOut)
    else $error("serial output active while disabled");
  a_sdo_quiet: assert property (linkPins.frameSelectN [*8] ##0 $stable(funcControl)
    |=> $stable(serialDataOut))
    else $error("serial output moved outside a frame");
endmodule

bind qdc_serial_load_control qdc_serial_load_control_monitor mon (.clock, .rst, .linkPins,
  .serialDataOut, .dacCode, .outputsClamped, .funcControl, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_dat_o);

// ### verif/qdc_serial_load_control_tb.sv
// Purpose: Self-checking bench for the quad converter serial load control.
// Assumes: Host model drives the link; bench drives pins and Wishbone.
// Notes:   Rows use load held low; awkward cases follow by hand.
`timescale 1ns/1ps
module qdc_serial_load_control_tb
  import qdc_pkg::*;
;
  typedef struct packed {
    logic [23:0]  word;
    logic [1:0]   chan;
    logic         cod;
    qdc_code_type want;
  } qdc_row_type;
  logic               clock  = 1'h0;
  logic               rst    = 1'h1;
  logic               loadN  = 1'h1;
  logic               clearN = 1'h1;
  logic               coding = 1'h0;
  logic               cyc    = 1'h0;
  logic               stb    = 1'h0;
  logic               we     = 1'h0;
  logic [7:0]         adr    = 8'h00;
  logic [31:0]        wdat   = 32'h0000_0000;
  logic [3:0]         sel    = 4'h0;
  logic               sclk, fsN, sdi, serial_data_out, ack, clamped;
  logic [31:0]        rdat, q;
  logic [47:0]        got;
  qdc_code_type [3:0] dacCode;
  qdc_func_type       funcControl;
  qdc_link_pins_type  linkPins;
  int                 miscompares    = 0;
  int                 samplesChecked = 0;
  int                 cycles         = 0;
  qdc_row_type        rows [7] = '{'{24'h10_1234, 2'h0, 1'h1, 16'h1234},
    '{24'h11_ABCD, 2'h1, 1'h0, 16'h2BCD}, '{24'h12_0001, 2'h2, 1'h1, 16'h0001},
    '{24'h13_FFFF, 2'h3, 1'h0, 16'h7FFF}, '{24'h14_5555, 2'h2, 1'h1, 16'h5555},
    '{24'h18_0000, 2'h2, 1'h1, 16'h5555}, '{24'h28_0000, 2'h0, 1'h1, 16'h5555}};
  assign linkPins = {sclk, fsN, sdi, loadN, clearN, coding};
  qdc_host_model host (.serialClock(sclk), .frameSelectN(fsN), .serialDataIn(sdi),
    .serialDataOut(serial_data_out));
  qdc_serial_load_control uut (.clock(clock), .rst(rst), .linkPins(linkPins),
    .serialDataOut(serial_data_out), .dacCode(dacCode), .outputsClamped(clamped),
    .funcControl(funcControl), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samplesChecked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clock); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    sel <= 4'h0;
  endtask
  task automatic send(input logic [47:0] w, input int n);
    host.frame(w, n, got);
  endtask
  task automatic settle;
    repeat (10) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    settle;
    check(dacCode[0], 16'h8000);
    check(clamped, 1'h1);
    check(funcControl, 6'h00);
    $display("test reset done");
    @(posedge clock);
    coding <= 1'h1;
    send(48'h0000_0010_1234, 24);
    send(48'h0000_0011_4321, 24);
    check(dacCode[0], 16'h0000);
    wb(1'h0, 8'h20, 32'h0000_0000);
    check(q, 32'h0000_1234);
    @(posedge clock);
    loadN <= 1'h0;
    settle;
    check(dacCode[0], 16'h1234);
    check(dacCode[1], 16'h4321);
    check(clamped, 1'h0);
    $display("test load done");
    foreach (rows[i]) begin
      @(posedge clock);
      coding <= rows[i].cod;
      settle;
      send({24'h00_0000, rows[i].word}, 24);
      check(dacCode[rows[i].chan], rows[i].want);
    end
    $display("test rows done");
    send(48'h0000_0010_0BAD, 23);
    send(48'h0000_0010_0BAD, 25);
    check(dacCode[0], 16'h5555);
    wb(1'h0, 8'h04, 32'h0000_0000);
    check(q[15:8], 8'h02);
    $display("test invalid done");
    send(48'h0000_0020_00FF, 24);
    send(48'h0000_00A0_0000, 24);
    send(48'h0000_0000_0000, 24);
    check(got[23:0], 24'h00_003F);
    send(48'h0000_0090_7777, 24);
    send(48'h0000_0000_0000, 24);
    check(got[23:0], 24'h00_5555);
    check(dacCode[0], 16'h5555);
    send(48'h0000_0001_0001, 24);
    check(funcControl, 6'h01);
    send(48'h0000_0000_0000, 24);
    check(got[23:0], 24'h00_0000);
    send(48'h0000_0001_0020, 24);
    check(funcControl, 6'h20);
    send(48'h0000_0081_0000, 24);
    send(48'h0000_0000_0000, 24);
    check(got[23:0], 24'h00_0020);
    $display("test readback done");
    @(posedge clock);
    coding <= 1'h0;
    loadN <= 1'h1;
    settle;
    clearN <= 1'h0;
    settle;
    clearN <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      check(dacCode[k], 16'h8000);
    end
    send(48'h0000_0010_0042, 24);
    check(dacCode[0], 16'h8000);
    @(posedge clock);
    loadN <= 1'h0;
    settle;
    check(dacCode[0], 16'h8042);
    @(posedge clock);
    loadN <= 1'h1;
    send(48'h0000_0004_0000, 24);
    check(dacCode[0], 16'h8000);
    send(48'h0000_0011_0007, 24);
    check(dacCode[1], 16'h8000);
    send(48'h0000_0005_0000, 24);
    check(dacCode[1], 16'h8007);
    $display("test clear done");
    wb(1'h1, 8'h00, 32'h0000_0001);
    @(posedge clock);
    loadN <= 1'h0;
    send(48'h12_0011_10_0066, 48);
    check(got[23:0], 24'h12_0011);
    check(dacCode[0], 16'h8066);
    check(dacCode[2], 16'h8000);
    wb(1'h0, 8'hF0, 32'h0000_0000);
    check(q, 32'h0000_0000);
    wb(1'h1, 8'hF0, 32'hFFFF_FFFF);
    wb(1'h0, 8'h00, 32'h0000_0000);
    check(q, 32'h0000_0001);
    $display("test daisy done");
    @(posedge clock);
    rst <= 1'h1;
    loadN <= 1'h1;
    clearN <= 1'h0;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    settle;
    check(clamped, 1'h0);
    check(dacCode[3], 16'h8000);
    check(funcControl, 6'h00);
    clearN <= 1'h1;
    $display("test power-on clear done");
    complete_run;
  end
endmodule
